// ===== tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module tb;
    import usbir_pkg::*;
    logic clk_sys, sys_rst, bus16_mode, enum_done, cs, ws, rs, alloc, dev_en, dma16;
    logic rsm, susp, irq, led_n, pu;
    logic [7:0] code;
    logic [15:0] wd, rdd, hw, v;
    logic [6:0] addr;
    usbir_usb_evt_t evt;
    usbir_ep_cfg_t [15:0] ep_cfg;
    int error_cnt, tests_run, allocs, n;

    usbir_regs #(.RESUME_DELAY_CYC(20), .RESUME_DRIVE_CYC(40)) dut_u (.clk_sys(clk_sys),
        .sys_rst(sys_rst), .cmd_strobe(cs), .cmd_code(code), .wr_strobe(ws), .wr_data(wd),
        .rd_strobe(rs), .bus16_mode(bus16_mode), .rd_data(rdd), .usb_evt(evt),
        .enum_done(enum_done), .ep_cfg(ep_cfg), .buffer_alloc_start(alloc),
        .device_address_field(addr), .device_enable_bit(dev_en), .dma_width_select(dma16),
        .hardware_setup(hw), .resume_drive(rsm), .suspend_active(susp), .usb_irq(irq),
        .link_led_n(led_n), .pullup_attach(pu));
    usbir_mcu_model mcu_u (.clk_sys(clk_sys), .cmd_strobe(cs), .cmd_code(code),
        .wr_strobe(ws), .wr_data(wd), .rd_strobe(rs), .rd_data(rdd));

    // clock and allocation pulse counter
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) if (alloc === 1'b1) allocs++;

    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
        #2;
    endtask : tick
    task automatic pulse(input usbir_usb_evt_t e);
        @(posedge clk_sys);
        #2 evt = e;
        @(posedge clk_sys);
        #2 evt = '0;
    endtask : pulse

    task automatic t_regs;
        mcu_u.rd(8'hBB, 1'b0, v);
        `CHK(v, 16'h2344)
        mcu_u.wr(8'hBA, 16'h4A5B, 1'b0);
        mcu_u.wr(8'hB8, 16'hFF9F, 1'b0);
        mcu_u.rd(8'hB9, 1'b0, v);
        `CHK({v, dma16, pu}, 18'h0027E)
        bus16_mode = 1'b0;
        mcu_u.wr(8'hBA, 16'h0A5B, 1'b1);
        mcu_u.rd(8'hBB, 1'b1, v);
        `CHK({v[7:0], hw, pu}, 25'h1414B7)
    endtask : t_regs

    task automatic t_ep;
        logic [7:0] d;
        for (int i = 0; i < 16; i++) begin
            d = {1'b1, i[2:0], i[3:0]};
            mcu_u.wr(8'h20 + 8'(i), {8'h00, d}, 1'b0);
            mcu_u.rd(8'h30 + 8'(i), 1'b0, v);
            `CHK({v[7:0], ep_cfg[i]}, {d, d})
        end
        mcu_u.wr(8'h2F, 16'h0081, 1'b0);
        `CHK(allocs, 1)
        pulse(8'h80);
        for (int i = 0; i < 16; i++) `CHK(ep_cfg[i].buffer_enable, 1'b0)
        `CHK({dev_en, addr, hw}, 24'h800A5B)
        mcu_u.rd(8'hB9, 1'b0, v);
        `CHK(v[7:0], 8'h8F)
    endtask : t_ep

    task automatic t_addr;
        mcu_u.wr(8'hB6, 16'h0085, 1'b0);
        tick(3);
        `CHK({dev_en, addr}, 8'h80)
        mcu_u.rd(8'hB7, 1'b0, v);
        `CHK(v, 16'h0085)
        pulse(8'h40);
        tick(1);
        `CHK({dev_en, addr}, 8'h85)
    endtask : t_addr

    // mode, event, expected interrupt
    task automatic t_irq;
        logic [19:0] tbl [8] = '{20'h0C081, 20'h0C041, 20'h0C200, 20'h08201,
            20'h08121, 20'h08080, 20'h00200, 20'h04080};
        foreach (tbl[k]) begin
            mcu_u.wr(8'hB8, {8'h00, tbl[k][19:12]}, 1'b0);
            pulse(tbl[k][11:4]);
            `CHK(irq, tbl[k][0])
        end
    endtask : t_irq

    task automatic t_power;
        mcu_u.wr(8'hB8, 16'h0020, 1'b0);
        `CHK(susp, 1'b0)
        mcu_u.wr(8'hB8, 16'h0000, 1'b0);
        tick(1);
        `CHK(susp, 1'b1)
        mcu_u.wr(8'hB8, 16'h0040, 1'b0);
        mcu_u.wr(8'hB8, 16'h0000, 1'b0);
        for (n = 0; rsm !== 1'b1 && n < 100; n++) tick(1);
        `CHK(n > 18 && n < 23, 1'b1)
        for (n = 0; rsm === 1'b1 && n < 100; n++) tick(1);
        `CHK(n, 40)
        `CHK(susp, 1'b0)
    endtask : t_power

    task automatic t_led;
        `CHK(led_n, 1'b1)
        enum_done = 1'b1;
        pulse(8'h01);
        tick(1);
        `CHK(led_n, 1'b1)
        pulse(8'h01);
        tick(1);
        `CHK(led_n, 1'b0)
        mcu_u.wr(8'hB8, 16'h0002, 1'b0);
        pulse(8'h01);
        tick(1);
        `CHK(led_n, 1'b0)
    endtask : t_led

    task automatic summarize;
        if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : summarize

    // a hang is cut short well past the expected few hundred cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        summarize();
    end

    initial begin
        sys_rst = 1'b1;
        bus16_mode = 1'b1;
        enum_done = 1'b0;
        evt = '0;
        repeat (20) @(posedge clk_sys);
        #2 sys_rst = 1'b0;
        t_regs();
        t_ep();
        t_addr();
        t_irq();
        t_power();
        t_led();
        summarize();
    end
endmodule : tb

// ===== usbir_mcu_model.sv
`timescale 1ns/1ps

module usbir_mcu_model (
    // clock
    input wire logic clk_sys,
    // command port towards the register block
    output logic cmd_strobe,
    output logic [7:0] cmd_code,
    output logic wr_strobe,
    output logic [15:0] wr_data,
    output logic rd_strobe,
    input wire logic [15:0] rd_data
);
    // port idles quiet until the first command
    initial begin
        cmd_strobe = 1'b0;
        cmd_code = 8'h00;
        wr_strobe = 1'b0;
        wr_data = 16'h0000;
        rd_strobe = 1'b0;
    end

    // one command cycle, changed just after an edge
    task automatic cmd(input logic [7:0] c);
        @(posedge clk_sys);
        #2 cmd_strobe = 1'b1;
        cmd_code = c;
        @(posedge clk_sys);
        #2 cmd_strobe = 1'b0;
    endtask : cmd

    // with two set, strobe stays up for a second beat: upper byte in 8-bit mode
    task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic two);
        cmd(c);
        wr_strobe = 1'b1;
        wr_data = two ? {8'h00, d[7:0]} : d;
        @(posedge clk_sys);
        #2 wr_data = {8'h00, d[15:8]};
        if (two) begin
            @(posedge clk_sys);
            #2;
        end
        wr_strobe = 1'b0;
    endtask : wr

    // hi asks for the upper byte of a two-byte register
    task automatic rd(input logic [7:0] c, input logic hi, output logic [15:0] v);
        cmd(c);
        if (hi) begin
            rd_strobe = 1'b1;
            @(posedge clk_sys);
            #2 rd_strobe = 1'b0;
        end
        @(posedge clk_sys);
        #2 v = rd_data;
    endtask : rd
endmodule : usbir_mcu_model

// ===== usbir_params.svh
`ifndef USBIR_PARAMS_SVH
`define USBIR_PARAMS_SVH

// command codes of the parallel interface
`define USBIR_CMD_EP_WR_BASE 8'h20
`define USBIR_CMD_EP_RD_BASE 8'h30
`define USBIR_CMD_GROUP_MASK 8'hF0
`define USBIR_CMD_ADDR_WR 8'hB6
`define USBIR_CMD_ADDR_RD 8'hB7
`define USBIR_CMD_MODE_WR 8'hB8
`define USBIR_CMD_MODE_RD 8'hB9
`define USBIR_CMD_HWCFG_WR 8'hBA
`define USBIR_CMD_HWCFG_RD 8'hBB

// endpoint setup register fields
`define USBIR_EP_ENABLE_BIT 7
`define USBIR_EP_DIR_BIT 6
`define USBIR_EP_DBL_BIT 5
`define USBIR_EP_ISO_BIT 4
`define USBIR_EP_SIZE_MSB 3
`define USBIR_EP_SIZE_LSB 0
`define USBIR_EP_COUNT 16
`define USBIR_EP_LAST_INDEX 4'hF

// device address register fields
`define USBIR_ADDR_EN_BIT 7
`define USBIR_ADDR_MSB 6
`define USBIR_ADDR_RESET 8'h00
`define USBIR_ADDR_BUS_RESET 8'h80

// operating mode register fields
`define USBIR_MODE_DMA16_BIT 7
`define USBIR_MODE_RESUME_BIT 6
`define USBIR_MODE_SUSPEND_BIT 5
`define USBIR_MODE_RSVD_BIT 4
`define USBIR_MODE_IRQEN_BIT 3
`define USBIR_MODE_DEBUG_BIT 2
`define USBIR_MODE_LEDFIX_BIT 1
`define USBIR_MODE_SOFTATT_BIT 0
`define USBIR_MODE_RESET 8'h00
`define USBIR_MODE_KEEP_MASK 8'h8F

// hardware setup register fields
`define USBIR_HW_EXTPU_BIT 14
`define USBIR_HW_RESET 16'h2344

// timing
`define USBIR_CLK_KHZ 40000
`define USBIR_RESUME_DELAY_MS 5
`define USBIR_RESUME_DRIVE_MS 10
`define USBIR_RESUME_DELAY_CYC (`USBIR_RESUME_DELAY_MS * `USBIR_CLK_KHZ)
`define USBIR_RESUME_DRIVE_CYC (`USBIR_RESUME_DRIVE_MS * `USBIR_CLK_KHZ)

`endif

// ===== usbir_pkg.sv
package usbir_pkg;
    // one endpoint setup byte
    typedef struct packed {
        logic buffer_enable;
        logic endpoint_direction;
        logic double_buffer_select;
        logic isochronous_select;
        logic [3:0] buffer_size_code;
    } usbir_ep_cfg_t;

    // events reported by the serial engine
    typedef struct packed {
        logic bus_reset;
        logic status_ack;
        logic ack;
        logic xfer_done;
        logic nak;
        logic error;
        logic iso;
        logic traffic;
    } usbir_usb_evt_t;

    typedef enum logic [1:0] {
        USBIR_RSM_IDLE = 2'b00,
        USBIR_RSM_WAIT = 2'b01,
        USBIR_RSM_DRIVE = 2'b10
    } usbir_rsm_state_t;
endpackage : usbir_pkg

// ===== usbir_regs.sv
`timescale 1ns/1ps
`include "usbir_params.svh"

// Overview of operation
// [RULE1] bit 7 enables endpoint buffer
// [RULE2] bit 6 selects direction and dma direction
// [RULE3] bit 5 selects two alternating buffers
// [RULE4] bit 4 selects isochronous transfer type
// [RULE5] bits 3..0 select buffer size code
// [RULE6] bus reset loads address zero, enabled
// [RULE7] firmware writes address, then sends empty packet
// [RULE8] new address active after status acknowledge
// [RULE9] address register: enable bit7, address 6..0
// [RULE10] one-byte mode register, upper byte ignored
// [RULE11] mode bit 7 selects 16-bit dma
// [RULE12] bit6 one-then-zero: 5ms wait, 10ms resume
// [RULE13] bit5 one-then-zero enters suspend
// [RULE14] mode bit 3 gates all interrupts
// [RULE15] bit 2 selects nak/error or ack/transfer interrupts
// [RULE16] bit 1 holds led on after enumeration
// [RULE17] bit 0 attaches pull-up unless external
// [RULE18] mode bits 7,3..0 survive bus reset
// [RULE19] two-byte hardware setup, kept on bus reset
// [RULE20] endpoint codes 20-2F write, 30-3F read
// [RULE21] allocation after ordered write of all sixteen
// [RULE22] bus reset disables every endpoint
// [RULE23] reserved mode bit 4 stored only
module usbir_regs #(
    parameter int unsigned RESUME_DELAY_CYC = `USBIR_RESUME_DELAY_CYC,
    parameter int unsigned RESUME_DRIVE_CYC = `USBIR_RESUME_DRIVE_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // command interface from the local controller front end
    input wire logic cmd_strobe,
    input wire logic [7:0] cmd_code,
    input wire logic wr_strobe,
    input wire logic [15:0] wr_data,
    input wire logic rd_strobe,
    input wire logic bus16_mode,
    output logic [15:0] rd_data,
    // usb side events and status
    input wire usbir_pkg::usbir_usb_evt_t usb_evt,
    input wire logic enum_done,
    // configuration outputs
    output usbir_pkg::usbir_ep_cfg_t [15:0] ep_cfg,
    output logic buffer_alloc_start,
    output logic [6:0] device_address_field,
    output logic device_enable_bit,
    output logic dma_width_select,
    output logic [15:0] hardware_setup,
    // device control outputs
    output logic resume_drive,
    output logic suspend_active,
    output logic usb_irq,
    output logic link_led_n,
    output logic pullup_attach
);
    import usbir_pkg::*;

    localparam int unsigned CNT_W = 24;

    // register file state
    usbir_ep_cfg_t [15:0] ep_q, ep_d;
    logic [7:0] addr_wr_q, addr_wr_d;
    logic [7:0] addr_act_q, addr_act_d;
    logic addr_pend_q, addr_pend_d;
    logic [7:0] mode_q, mode_d;
    logic [15:0] hw_q, hw_d;
    logic [7:0] cmd_q, cmd_d;
    logic hi_phase_q, hi_phase_d;
    logic [15:0] rd_q, rd_d;
    logic [3:0] seq_q, seq_d;
    logic seq_ok_q, seq_ok_d;
    logic alloc_q, alloc_d;
    logic resume_req, suspend_req;

    // register write decoding; one data phase per command, two for hardware setup in 8-bit mode
    always_comb begin
        logic [3:0] idx;
        idx = cmd_q[3:0];
        ep_d = ep_q;
        addr_wr_d = addr_wr_q;
        addr_act_d = addr_act_q;
        addr_pend_d = addr_pend_q;
        mode_d = mode_q;
        hw_d = hw_q;
        cmd_d = cmd_q;
        hi_phase_d = hi_phase_q;
        rd_d = rd_q;
        seq_d = seq_q;
        seq_ok_d = seq_ok_q;
        alloc_d = 1'b0;
        resume_req = 1'b0;
        suspend_req = 1'b0;
        // acknowledge applies the pending address; a same-cycle write re-arms it
        if (usb_evt.status_ack && addr_pend_q) begin
            addr_act_d = addr_wr_q; // [RULE8]
            addr_pend_d = 1'b0;
        end
        if (cmd_strobe) begin
            cmd_d = cmd_code;
            hi_phase_d = 1'b0;
            // read data is latched when the read command is taken
            if ((cmd_code & `USBIR_CMD_GROUP_MASK) == `USBIR_CMD_EP_RD_BASE) begin
                rd_d = {8'h00, ep_q[cmd_code[3:0]]};
            end else if (cmd_code == `USBIR_CMD_ADDR_RD) begin
                rd_d = {8'h00, addr_wr_q}; // [RULE9]
            end else if (cmd_code == `USBIR_CMD_MODE_RD) begin
                rd_d = {8'h00, mode_q}; // [RULE10] [RULE23]
            end else if (cmd_code == `USBIR_CMD_HWCFG_RD) begin
                rd_d = bus16_mode ? hw_q : {8'h00, hw_q[7:0]}; // [RULE19]
            end
        end else if (rd_strobe && cmd_q == `USBIR_CMD_HWCFG_RD && !bus16_mode) begin
            // second byte of the hardware setup read in 8-bit mode
            rd_d = {8'h00, hw_q[15:8]};
            hi_phase_d = 1'b1;
        end else if (wr_strobe) begin
            if ((cmd_q & `USBIR_CMD_GROUP_MASK) == `USBIR_CMD_EP_WR_BASE) begin
                ep_d[idx] = usbir_ep_cfg_t'(wr_data[7:0]); // [RULE1] [RULE2] [RULE3] [RULE4] [RULE5] [RULE20]
                // sequence must run control out first through endpoint 15
                if (idx == seq_q && (seq_ok_q || idx == 4'h0)) begin
                    seq_d = idx + 4'h1;
                    seq_ok_d = 1'b1;
                    alloc_d = (idx == `USBIR_EP_LAST_INDEX); // [RULE21]
                end else begin
                    seq_d = (idx == 4'h0) ? 4'h1 : 4'h0;
                    seq_ok_d = (idx == 4'h0);
                end
                if (alloc_d) begin
                    seq_d = 4'h0;
                    seq_ok_d = 1'b0;
                end
            end else if (cmd_q == `USBIR_CMD_ADDR_WR) begin
                addr_wr_d = wr_data[7:0]; // [RULE9]
                addr_pend_d = 1'b1; // [RULE8]
            end else if (cmd_q == `USBIR_CMD_MODE_WR) begin
                mode_d = wr_data[7:0]; // [RULE10] [RULE23]
                // a one followed by a zero arms the strobe actions
                resume_req = mode_q[`USBIR_MODE_RESUME_BIT]
                    && !wr_data[`USBIR_MODE_RESUME_BIT]; // [RULE12]
                suspend_req = mode_q[`USBIR_MODE_SUSPEND_BIT]
                    && !wr_data[`USBIR_MODE_SUSPEND_BIT]; // [RULE13]
            end else if (cmd_q == `USBIR_CMD_HWCFG_WR) begin
                if (bus16_mode) begin
                    hw_d = wr_data; // [RULE19]
                end else if (!hi_phase_q) begin
                    hw_d[7:0] = wr_data[7:0];
                    hi_phase_d = 1'b1;
                end else begin
                    hw_d[15:8] = wr_data[7:0];
                end
            end
        end
        // bus reset beats a same-cycle address write and endpoint enable; a mode write keeps bits 7,3..0, a hardware setup write lands
        if (usb_evt.bus_reset) begin
            addr_wr_d = `USBIR_ADDR_BUS_RESET; // [RULE6]
            addr_act_d = `USBIR_ADDR_BUS_RESET;
            addr_pend_d = 1'b0;
            mode_d = mode_d & `USBIR_MODE_KEEP_MASK; // [RULE18]
            for (int i = 0; i < `USBIR_EP_COUNT; i++) begin
                ep_d[i].buffer_enable = 1'b0; // [RULE22]
            end
            resume_req = 1'b0;
            suspend_req = 1'b0;
        end
    end

    // register file flops; hardware setup is untouched by bus reset
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ep_q <= '0;
            addr_wr_q <= `USBIR_ADDR_RESET;
            addr_act_q <= `USBIR_ADDR_RESET;
            addr_pend_q <= 1'b0;
            mode_q <= `USBIR_MODE_RESET; // [RULE18]
            hw_q <= `USBIR_HW_RESET;
            cmd_q <= 8'h00;
            hi_phase_q <= 1'b0;
            rd_q <= 16'h0000;
            seq_q <= 4'h0;
            seq_ok_q <= 1'b0;
            alloc_q <= 1'b0;
        end else begin
            ep_q <= ep_d;
            addr_wr_q <= addr_wr_d;
            addr_act_q <= addr_act_d;
            addr_pend_q <= addr_pend_d;
            mode_q <= mode_d;
            hw_q <= hw_d;
            cmd_q <= cmd_d;
            hi_phase_q <= hi_phase_d;
            rd_q <= rd_d;
            seq_q <= seq_d;
            seq_ok_q <= seq_ok_d;
            alloc_q <= alloc_d;
        end
    end

    // resume, suspend, interrupt and led state
    usbir_rsm_state_t rsm_q, rsm_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic susp_q, susp_d;
    logic irq_q, irq_d;
    logic blink_q, blink_d;
    logic led_n_q, led_n_d;
    logic irq_src;

    always_comb begin
        rsm_d = rsm_q;
        cnt_d = cnt_q;
        susp_d = susp_q;
        blink_d = blink_q;
        case (rsm_q)
            USBIR_RSM_IDLE: begin
                if (resume_req) begin
                    rsm_d = USBIR_RSM_WAIT;
                    cnt_d = CNT_W'(RESUME_DELAY_CYC - 1);
                end
            end
            USBIR_RSM_WAIT: begin
                if (cnt_q == '0) begin
                    rsm_d = USBIR_RSM_DRIVE; // [RULE12]
                    cnt_d = CNT_W'(RESUME_DRIVE_CYC - 1);
                end else begin
                    cnt_d = cnt_q - CNT_W'(1);
                end
            end
            USBIR_RSM_DRIVE: begin
                if (cnt_q == '0) begin
                    rsm_d = USBIR_RSM_IDLE;
                end else begin
                    cnt_d = cnt_q - CNT_W'(1);
                end
            end
            default: begin
                rsm_d = USBIR_RSM_IDLE;
            end
        endcase
        // suspend holds until bus reset or upstream resume begins
        if (suspend_req) begin
            susp_d = 1'b1; // [RULE13]
        end else if (usb_evt.bus_reset || rsm_q == USBIR_RSM_DRIVE) begin
            susp_d = 1'b0;
        end
        if (usb_evt.bus_reset) begin
            rsm_d = USBIR_RSM_IDLE;
        end
        // debug mode reports failures, normal mode reports completions
        if (mode_q[`USBIR_MODE_DEBUG_BIT]) begin
            irq_src = usb_evt.nak || usb_evt.error; // [RULE15]
        end else begin
            irq_src = usb_evt.iso ? usb_evt.xfer_done : usb_evt.ack;
        end
        irq_d = mode_q[`USBIR_MODE_IRQEN_BIT] && irq_src; // [RULE14]
        // led stays off until enumeration, then toggles per traffic burst unless held on
        if (usb_evt.traffic) begin
            blink_d = ~blink_q;
        end
        if (!enum_done) begin
            led_n_d = 1'b1;
        end else if (mode_q[`USBIR_MODE_LEDFIX_BIT]) begin
            led_n_d = 1'b0; // [RULE16]
        end else begin
            led_n_d = blink_q;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rsm_q <= USBIR_RSM_IDLE;
            cnt_q <= '0;
            susp_q <= 1'b0;
            irq_q <= 1'b0;
            blink_q <= 1'b0;
            led_n_q <= 1'b1;
        end else begin
            rsm_q <= rsm_d;
            cnt_q <= cnt_d;
            susp_q <= susp_d;
            irq_q <= irq_d;
            blink_q <= blink_d;
            led_n_q <= led_n_d;
        end
    end

    // outputs, all straight from flops apart from the pull-up gate and the resume_drive state decode
    assign ep_cfg = ep_q;
    assign buffer_alloc_start = alloc_q;
    assign rd_data = rd_q;
    assign device_address_field = addr_act_q[`USBIR_ADDR_MSB:0];
    assign device_enable_bit = addr_act_q[`USBIR_ADDR_EN_BIT];
    assign dma_width_select = mode_q[`USBIR_MODE_DMA16_BIT]; // [RULE11]
    assign hardware_setup = hw_q;
    assign resume_drive = (rsm_q == USBIR_RSM_DRIVE);
    assign suspend_active = susp_q;
    assign usb_irq = irq_q;
    assign link_led_n = led_n_q;
    // an external pull-up overrides the software attach
    assign pullup_attach = mode_q[`USBIR_MODE_SOFTATT_BIT]
        && !hw_q[`USBIR_HW_EXTPU_BIT]; // [RULE17]

endmodule : usbir_regs

// ===== usbir_regs_sva.sv
`timescale 1ns/1ps

module usbir_regs_sva (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // command port
    input wire logic cmd_strobe,
    input wire logic [7:0] cmd_code,
    input wire logic wr_strobe,
    input wire logic [15:0] wr_data,
    // usb side
    input wire usbir_pkg::usbir_usb_evt_t usb_evt,
    input wire logic enum_done,
    // watched outputs
    input wire usbir_pkg::usbir_ep_cfg_t [15:0] ep_cfg,
    input wire logic [6:0] device_address_field,
    input wire logic device_enable_bit,
    input wire logic dma_width_select,
    input wire logic [15:0] hardware_setup,
    input wire logic resume_drive,
    input wire logic suspend_active,
    input wire logic usb_irq,
    input wire logic link_led_n,
    input wire logic pullup_attach
);
    import usbir_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    localparam int RSM_MAX = 23;
    logic [7:0] cur_q;
    logic [7:0] mode_q;
    logic wr_ev;
    logic any_en;
    assign wr_ev = wr_strobe && !cmd_strobe;

    // shadow of command and mode byte; bus reset wins over a write
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cur_q <= 8'h00;
            mode_q <= 8'h00;
        end else begin
            if (cmd_strobe) cur_q <= cmd_code;
            if (usb_evt.bus_reset) mode_q <= mode_q & 8'h8F;
            else if (wr_ev && cur_q == 8'hB8) mode_q <= wr_data[7:0];
        end
    end

    // any endpoint still holding its buffer
    always_comb begin
        any_en = 1'b0;
        for (int i = 0; i < 16; i++) any_en = any_en | ep_cfg[i].buffer_enable;
    end

    sequence s_mode_wr;
        wr_ev && cur_q == 8'hB8 && !usb_evt.bus_reset;
    endsequence
    sequence s_resume_go;
        s_mode_wr ##0 (mode_q[6] && !wr_data[6] && !resume_drive);
    endsequence
    sequence s_susp_go;
        s_mode_wr ##0 (mode_q[5] && !wr_data[5]);
    endsequence

    a_irq_gated: assert property (usb_irq |-> $past(mode_q[3]))
        else $error("interrupt while globally disabled");
    a_irq_debug: assert property (mode_q[3] && mode_q[2] && (usb_evt.nak || usb_evt.error)
        |=> usb_irq) else $error("debug mode event gave no interrupt");
    a_irq_ack: assert property (mode_q[3] && !mode_q[2] && !usb_evt.iso && usb_evt.ack
        |=> usb_irq) else $error("bulk ack gave no interrupt");
    a_dma_width: assert property (s_mode_wr |=> dma_width_select == $past(wr_data[7]))
        else $error("dma width not from mode write");
    a_bus_reset: assert property (usb_evt.bus_reset |=> device_enable_bit && !any_en
        && device_address_field == 7'h00) else $error("bus reset state wrong");
    a_addr_hold: assert property (!$past(usb_evt.status_ack) && !$past(usb_evt.bus_reset)
        |-> $stable(device_address_field)) else $error("address moved early");
    a_resume_wait: assert property (s_resume_go |-> ##[1:RSM_MAX] resume_drive)
        else $error("resume not driven in time");
    a_susp_go: assert property (s_susp_go |=> suspend_active)
        else $error("suspend not entered");
    a_led_fixed: assert property (enum_done && mode_q[1] |=> !link_led_n)
        else $error("led not held on");
    a_pullup_mux: assert property (pullup_attach == (mode_q[0] && !hardware_setup[14]))
        else $error("pull-up attach wrong");
endmodule : usbir_regs_sva

bind usbir_regs usbir_regs_sva chk_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .cmd_strobe(cmd_strobe), .cmd_code(cmd_code), .wr_strobe(wr_strobe), .wr_data(wr_data),
    .usb_evt(usb_evt), .enum_done(enum_done), .ep_cfg(ep_cfg),
    .device_address_field(device_address_field), .device_enable_bit(device_enable_bit),
    .dma_width_select(dma_width_select), .hardware_setup(hardware_setup),
    .resume_drive(resume_drive), .suspend_active(suspend_active), .usb_irq(usb_irq),
    .link_led_n(link_led_n), .pullup_attach(pullup_attach));
